// ---- src/ilod_decode.sv ----
// Summary of operation
// RULE1: Extended set also enables indexed offset addressing.
// RULE2: Access clear, field <=5Fh: pointer plus offset.
// RULE3: Fields above 5Fh keep direct addressing.
// RULE4: Extended off: access bank or bank-select addressing.
// RULE5: Applies to all access-bit instructions.
// RULE6: Zero pointer matches original access-bank map.
// RULE7: Indexed encodings carry a cleared access bit.
// RULE8: Destination bit: 0 working reg, 1 file.
// RULE9: Indexed add updates five flags, one cycle.
// RULE10: Indexed bit set leaves flags, one cycle.
// RULE11: Indexed set-all writes FFh, flags kept.
// RULE12: Config bit zero disables extended decoding.
// RULE13: Address is pointer plus zero-extended offset.
// RULE14: Address space spans 000h to FFFh.
//
// Purpose: Operand address decode and execution of three representative
//          file operations, with APB access to control, pointer, bank, last word, decode and flags.
// Assumes: Instruction words and file bytes arrive synchronous to clk.
// Notes:   Each issued word produces its decode and result one cycle later.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module ilod_decode (
   // Clock, reset and enable
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   // Configuration
   input  wire logic        extended_set_config_bit,
   // Instruction issue
   input  wire logic        insn_valid,
   input  wire logic [15:0] insn_word,
   input  wire logic [7:0]  acc_in,
   input  wire logic [7:0]  file_rdata,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Decode and result
   output logic             res_valid,
   output logic [11:0]      eff_addr,
   output logic             res_indexed,
   output logic             res_to_file,
   output logic [7:0]       res_data,
   output logic             res_wr_file,
   output logic             res_wr_acc,
   output logic             res_flags_we,
   output logic [4:0]       res_flags
);

   // ----------------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------------

   // Forms the operand address; offsets wrap inside the 4 KB space.
   function automatic ilod_pkg::ilod_dec_t dec_word(
      input logic [15:0] w, input logic ext, input logic [11:0] ptr,
      input logic [3:0] bank);
      ilod_pkg::ilod_dec_t d;
      d = '0;
      d.dest_file = w[ilod_pkg::DST_BIT]; // see RULE8
      d.bit_sel   = w[11:9];
      if (w[15:10] == ilod_pkg::OPC_ADD) begin
         d.op = ilod_pkg::ILOD_OP_ADD;
      end else if (w[15:12] == ilod_pkg::OPC_BSET) begin
         d.op = ilod_pkg::ILOD_OP_BSET;
         d.dest_file = 1'b1;
      end else if (w[15:9] == ilod_pkg::OPC_SETALL) begin
         d.op = ilod_pkg::ILOD_OP_SETALL;
         d.dest_file = 1'b1;
      end
      // Redirect only with config set, access clear and a low field.
      // see RULE1 see RULE2 see RULE3 see RULE5 see RULE7 see RULE12
      if (ext && !w[ilod_pkg::ACC_BIT] && w[7:0] <= ilod_pkg::IDX_LIMIT)
      begin
         d.indexed = 1'b1;
         d.addr    = ptr + {4'h0, w[7:0]}; // see RULE13 see RULE14
      end else if (w[ilod_pkg::ACC_BIT]) begin
         d.addr = {bank, w[7:0]}; // see RULE4
      end else if (w[7:0] < ilod_pkg::ACCESS_SPLIT) begin
         d.addr = {4'h0, w[7:0]}; // see RULE4 see RULE6
      end else begin
         d.addr = {ilod_pkg::ACCESS_HI_BNK, w[7:0]};
      end
      return d;
   endfunction

   // ----------------------------------------------------------------------
   // Register file state
   // ----------------------------------------------------------------------
   logic [11:0] ptr_ff, nxt_ptr;
   logic [3:0]  bank_ff, nxt_bank;
   logic        ext_sw_ff, nxt_ext_sw;
   logic [15:0] last_insn_ff, nxt_last_insn;
   logic [31:0] prdata_ff, nxt_prdata;
   logic        pready_ff, nxt_pready;
   logic        pslverr_ff, nxt_pslverr;
   logic        ext_en;
   logic        apb_acc;
   logic        apb_done;
   logic        known;

   // Both the pin and the software gate must be set; a cleared pin wins.
   assign ext_en  = extended_set_config_bit & ext_sw_ff; // see RULE12
   assign apb_acc = psel & penable & ~pready_ff;
   assign apb_done = psel & penable & pready_ff;
   assign known   = paddr inside {ilod_pkg::REG_CTRL, ilod_pkg::REG_PTR,
                    ilod_pkg::REG_BANK, ilod_pkg::REG_INSN,
                    ilod_pkg::REG_RESULT, ilod_pkg::REG_STATUS};

   // ----------------------------------------------------------------------
   // Execute pipeline state
   // ----------------------------------------------------------------------
   logic        rv_ff, nxt_rv;
   ilod_pkg::ilod_dec_t dec_ff, nxt_dec;
   logic [7:0]  data_ff, nxt_data;
   logic        wf_ff, nxt_wf;
   logic        wa_ff, nxt_wa;
   logic        fwe_ff, nxt_fwe;
   ilod_pkg::ilod_flags_t flg_ff, nxt_flg;

   // APB: one wait state, so every access completes in its second cycle.
   always_comb begin
      nxt_ptr       = ptr_ff;
      nxt_bank      = bank_ff;
      nxt_ext_sw    = ext_sw_ff;
      nxt_prdata    = prdata_ff;
      nxt_pready    = apb_acc;
      nxt_pslverr   = apb_acc & ~known;
      nxt_last_insn = last_insn_ff;
      if (insn_valid) begin
         nxt_last_insn = insn_word;
      end
      if (apb_acc) begin
         nxt_prdata = 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               ilod_pkg::REG_CTRL:   nxt_prdata = {30'h0, ext_en, ext_sw_ff};
               ilod_pkg::REG_PTR:    nxt_prdata = {20'h0, ptr_ff};
               ilod_pkg::REG_BANK:   nxt_prdata = {28'h0, bank_ff};
               ilod_pkg::REG_INSN:   nxt_prdata = {16'h0, last_insn_ff};
               ilod_pkg::REG_RESULT: nxt_prdata = {19'h0, dec_ff.indexed,
                                                   dec_ff.addr};
               ilod_pkg::REG_STATUS: nxt_prdata = {27'h0, flg_ff};
               default:              nxt_prdata = 32'h0000_0000;
            endcase
         end
      end
      // Writes land at the completing edge, when the master sees pready.
      if (apb_done && pwrite) begin
         unique case (paddr)
            ilod_pkg::REG_CTRL: nxt_ext_sw = pwdata[0];
            ilod_pkg::REG_PTR:  nxt_ptr    = pwdata[11:0];
            ilod_pkg::REG_BANK: nxt_bank   = pwdata[3:0];
            default:            nxt_ptr    = ptr_ff;
         endcase
      end
   end

   // Register updates for the bus side.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ptr_ff       <= ilod_pkg::PTR_RST;
         bank_ff      <= ilod_pkg::BANK_RST;
         ext_sw_ff    <= ilod_pkg::CTRL_RST;
         last_insn_ff <= ilod_pkg::INSN_RST;
         prdata_ff    <= 32'h0000_0000;
         pready_ff    <= 1'b0;
         pslverr_ff   <= 1'b0;
      end else if (clk_en) begin
         ptr_ff       <= nxt_ptr;
         bank_ff      <= nxt_bank;
         ext_sw_ff    <= nxt_ext_sw;
         last_insn_ff <= nxt_last_insn;
         prdata_ff    <= nxt_prdata;
         pready_ff    <= nxt_pready;
         pslverr_ff   <= nxt_pslverr;
      end
   end

   // Single-cycle execute of add, bit set and set-all.
   always_comb begin
      ilod_pkg::ilod_dec_t d;
      logic [8:0] sum;
      logic [4:0] low;
      d        = dec_word(insn_word, ext_en, ptr_ff, bank_ff);
      sum      = {1'b0, acc_in} + {1'b0, file_rdata};
      low      = {1'b0, acc_in[3:0]} + {1'b0, file_rdata[3:0]};
      nxt_rv   = insn_valid;
      nxt_dec  = insn_valid ? d : dec_ff;
      nxt_data = 8'h00;
      nxt_wf   = 1'b0;
      nxt_wa   = 1'b0;
      nxt_fwe  = 1'b0;
      nxt_flg  = flg_ff;
      if (insn_valid) begin
         unique case (d.op)
            ilod_pkg::ILOD_OP_ADD: begin // see RULE9
               nxt_data    = sum[7:0];
               nxt_wf      = d.dest_file;
               nxt_wa      = ~d.dest_file; // see RULE8
               nxt_fwe     = 1'b1;
               nxt_flg.neg    = sum[7];
               nxt_flg.ovf    = (acc_in[7] == file_rdata[7]) &&
                                (sum[7] != acc_in[7]);
               nxt_flg.carry  = sum[8];
               nxt_flg.dcarry = low[4];
               nxt_flg.zero   = (sum[7:0] == 8'h00);
            end
            ilod_pkg::ILOD_OP_BSET: begin // see RULE10
               nxt_data = file_rdata | (8'h01 << d.bit_sel);
               nxt_wf   = 1'b1;
            end
            ilod_pkg::ILOD_OP_SETALL: begin // see RULE11
               nxt_data = ilod_pkg::ALL_ONES;
               nxt_wf   = 1'b1;
            end
            ilod_pkg::ILOD_OP_OTHER: begin
               nxt_data = 8'h00;
            end
         endcase
      end
   end

   // Register updates for the execute side.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rv_ff   <= 1'b0;
         dec_ff  <= '0;
         data_ff <= 8'h00;
         wf_ff   <= 1'b0;
         wa_ff   <= 1'b0;
         fwe_ff  <= 1'b0;
         flg_ff  <= '0;
      end else if (clk_en) begin
         rv_ff   <= nxt_rv;
         dec_ff  <= nxt_dec;
         data_ff <= nxt_data;
         wf_ff   <= nxt_wf;
         wa_ff   <= nxt_wa;
         fwe_ff  <= nxt_fwe;
         flg_ff  <= nxt_flg;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign prdata       = prdata_ff;
   assign pready       = pready_ff;
   assign pslverr      = pslverr_ff;
   assign res_valid    = rv_ff;
   assign eff_addr     = dec_ff.addr;
   assign res_indexed  = dec_ff.indexed;
   assign res_to_file  = dec_ff.dest_file;
   assign res_data     = data_ff;
   assign res_wr_file  = wf_ff;
   assign res_wr_acc   = wa_ff;
   assign res_flags_we = fwe_ff;
   assign res_flags    = flg_ff;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   property p_idx_addr;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && insn_valid && ext_en && !insn_word[8] &&
       insn_word[7:0] <= 8'h5f) |=> (res_indexed &&
       eff_addr == $past(ptr_ff) + {4'h0, $past(insn_word[7:0])});
   endproperty
   a_idx_addr: assert property (p_idx_addr) // see RULE2
      else $error("indexed address wrong");

   property p_high_direct;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && insn_valid && !insn_word[8] && insn_word[7:0] > 8'h5f)
      |=> !res_indexed && eff_addr[7:0] == $past(insn_word[7:0]);
   endproperty
   a_high_direct: assert property (p_high_direct) // see RULE3
      else $error("high field redirected");

   property p_bank;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && insn_valid && insn_word[8]) |=>
      eff_addr == {$past(bank_ff), $past(insn_word[7:0])};
   endproperty
   a_bank: assert property (p_bank) // see RULE4
      else $error("bank address wrong");

   property p_cfg_off;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && insn_valid && !extended_set_config_bit) |=> !res_indexed;
   endproperty
   a_cfg_off: assert property (p_cfg_off) // see RULE12
      else $error("indexed with config clear");

   property p_setall;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && insn_valid && insn_word[15:9] == 7'h34) |=>
      (res_data == 8'hff && res_wr_file && !res_flags_we);
   endproperty
   a_setall: assert property (p_setall) // see RULE11
      else $error("set-all wrong");

   property p_bset;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && insn_valid && insn_word[15:12] == 4'h8) |=>
      (res_data[$past(insn_word[11:9])] && !res_flags_we &&
       $stable(res_flags));
   endproperty
   a_bset: assert property (p_bset) // see RULE10
      else $error("bit set wrong");

   property p_add_dest;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && insn_valid && insn_word[15:10] == 6'h09) |=>
      (res_flags_we && res_wr_acc == !$past(insn_word[9]) &&
       res_data == $past(acc_in) + $past(file_rdata));
   endproperty
   a_add_dest: assert property (p_add_dest) // see RULE9 see RULE8
      else $error("add result wrong");

   property p_apb;
      @(posedge clk) disable iff (sys_rst)
      (clk_en && psel && penable && !pready) |=> pready ##1 !pready;
   endproperty
   a_apb: assert property (p_apb)
      else $error("apb answer timing wrong");

endmodule

// ---- src/ilod_pkg.sv ----
// Purpose: Shared constants and types for the indexed literal offset decoder.
// Assumes: 12-bit data address space, 16-bit instruction words.
// Notes:   Register offsets are byte addresses on a 32-bit APB slave.
package ilod_pkg;

   // ----------------------------------------------------------------------
   // Address space and decode limits
   // ----------------------------------------------------------------------
   localparam int          ADDR_W        = 12;
   localparam logic [7:0]  IDX_LIMIT     = 8'h5f;
   localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
   localparam logic [3:0]  ACCESS_HI_BNK = 4'hf;

   // ----------------------------------------------------------------------
   // Opcode field positions and patterns
   // ----------------------------------------------------------------------
   localparam int          ACC_BIT       = 8;
   localparam int          DST_BIT       = 9;
   localparam logic [5:0]  OPC_ADD       = 6'h09;
   localparam logic [3:0]  OPC_BSET      = 4'h8;
   localparam logic [6:0]  OPC_SETALL    = 7'h34;
   localparam logic [7:0]  ALL_ONES      = 8'hff;

   // ----------------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [11:0] REG_CTRL      = 12'h000;
   localparam logic [11:0] REG_PTR       = 12'h004;
   localparam logic [11:0] REG_BANK      = 12'h008;
   localparam logic [11:0] REG_INSN      = 12'h00c;
   localparam logic [11:0] REG_RESULT    = 12'h010;
   localparam logic [11:0] REG_STATUS    = 12'h014;
   localparam logic        CTRL_RST      = 1'b0;
   localparam logic [11:0] PTR_RST       = 12'h000;
   localparam logic [3:0]  BANK_RST      = 4'h0;
   localparam logic [15:0] INSN_RST      = 16'h0000;

   // ----------------------------------------------------------------------
   // Carried types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ILOD_OP_OTHER,
      ILOD_OP_ADD,
      ILOD_OP_BSET,
      ILOD_OP_SETALL
   } ilod_op_t;

   typedef struct packed {
      logic [11:0] addr;
      logic        indexed;
      logic        dest_file;
      logic [2:0]  bit_sel;
      ilod_op_t    op;
   } ilod_dec_t;

   typedef struct packed {
      logic neg;
      logic ovf;
      logic carry;
      logic dcarry;
      logic zero;
   } ilod_flags_t;

endpackage

// ---- sim/ilod_decode_bench.sv ----
// Purpose: Self-checking bench for the indexed literal offset decoder.
// Assumes: APB answers after one wait state, results one cycle after issue.
// Notes:   Random words come from a fixed seed, boundary offsets mixed in.
`timescale 1ns/1ps
module ilod_decode_bench;
   // ---------------------------------------------------------------------
   // Stimulus, observed outputs and bench copy of the register state
   // ---------------------------------------------------------------------
   logic        clk         = 1'b0;
   logic        sys_rst     = 1'b1;
   logic        clk_en      = 1'b1;
   logic        ext_pin     = 1'b0;
   logic        insn_valid  = 1'b0;
   logic [15:0] insn_word   = 16'h0000;
   logic [7:0]  acc_in      = 8'h00;
   logic [7:0]  file_rdata  = 8'h00;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [11:0] paddr       = 12'h000;
   logic [31:0] pwdata      = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr, res_valid, res_indexed, res_to_file;
   logic [11:0] eff_addr;
   logic [7:0]  res_data;
   logic        res_wr_file, res_wr_acc, res_flags_we;
   logic [4:0]  res_flags, last_flags;
   logic        ctrl_sw;
   logic [11:0] ptr;
   logic [3:0]  bank;
   logic [15:0] last_word;
   logic [12:0] last_res;
   int          num_errors  = 0;
   int          checks_done = 0;

   // Half period of 2 ns gives the 250 MHz core clock.
   always #2 clk = ~clk;

   ilod_decode DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .extended_set_config_bit(ext_pin), .insn_valid(insn_valid),
      .insn_word(insn_word), .acc_in(acc_in), .file_rdata(file_rdata),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .res_valid(res_valid), .eff_addr(eff_addr),
      .res_indexed(res_indexed), .res_to_file(res_to_file),
      .res_data(res_data), .res_wr_file(res_wr_file),
      .res_wr_acc(res_wr_acc), .res_flags_we(res_flags_we),
      .res_flags(res_flags));

   // ---------------------------------------------------------------------
   // Expectation functions and shared tasks
   // ---------------------------------------------------------------------
   // Returns {indexed, address}; pointer sums wrap in the 4 KB space.
   function automatic logic [12:0] exp_addr(input logic [15:0] w);
      logic [7:0] f;
      f = w[7:0];
      if (ext_pin & ctrl_sw & ~w[8] & (f <= 8'h5f))
         return {1'b1, ptr + {4'h0, f}};
      if (w[8])
         return {1'b0, bank, f};
      return {1'b0, (f < 8'h60) ? 4'h0 : 4'hf, f};
   endfunction

   // Flags in the order neg, overflow, carry, digit carry, zero.
   function automatic logic [4:0] exp_flags(input logic [7:0] a,
                                            input logic [7:0] f);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, f};
      return {s[7], (a[7] == f[7]) && (s[7] != a[7]), s[8],
              ({1'b0, a[3:0]} + {1'b0, f[3:0]}) > 5'h0f, s[7:0] == 8'h00};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n;
      @(posedge clk);
      insn_valid <= 1'b0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         check(32'h0, 32'h1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wreg(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
      check(e, 1'b0);
      if (a == ilod_pkg::REG_CTRL) ctrl_sw = d[0];
      if (a == ilod_pkg::REG_PTR) ptr = d[11:0];
      if (a == ilod_pkg::REG_BANK) bank = d[3:0];
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] x,
                       input logic xe);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      check(q, x);
      check(e, xe);
   endtask

   // Issues one word for one cycle, then checks its result a cycle later.
   // Drives change only at a rising edge, so the next call waits one.
   task automatic issue(input logic [15:0] w, input logic [7:0] a,
                        input logic [7:0] f);
      logic [12:0] ea;
      logic        ad, bs, sa;
      ad = w[15:10] == ilod_pkg::OPC_ADD;
      bs = w[15:12] == ilod_pkg::OPC_BSET;
      sa = w[15:9] == ilod_pkg::OPC_SETALL;
      @(posedge clk);
      ea = exp_addr(w);
      insn_valid <= 1'b1;
      insn_word  <= w;
      acc_in     <= a;
      file_rdata <= f;
      @(posedge clk);
      insn_valid <= 1'b0;
      #1;
      check(res_valid, 1'b1);
      check(eff_addr, ea[11:0]);
      check(res_indexed, ea[12]);
      check(res_wr_file, (ad & w[9]) | bs | sa);
      check(res_wr_acc, ad & ~w[9]);
      check(res_flags_we, ad);
      if (ad) check(res_data, 8'(a + f));
      if (!ad) check(res_flags, last_flags);
      if (ad) check(res_flags, exp_flags(a, f));
      if (ad) check(res_to_file, w[9]);
      if (bs) check(res_data, f | (8'h01 << w[11:9]));
      if (sa) check(res_data, 8'hff);
      if (bs | sa) check(res_to_file, 1'b1);
      if (ad) last_flags = exp_flags(a, f);
      last_word = w;
      last_res  = ea;
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ---------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------
   initial begin
      int          i;
      logic [15:0] w;
      logic [7:0]  f;
      i = $urandom(23051);
      {ctrl_sw, ptr, bank, last_flags} = '0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      check(res_valid, 1'b0);
      check(eff_addr, 12'h000);
      rchk(ilod_pkg::REG_CTRL, 32'h0, 1'b0);
      rchk(ilod_pkg::REG_PTR, 32'h0, 1'b0);
      rchk(ilod_pkg::REG_BANK, 32'h0, 1'b0);
      rchk(12'h018, 32'h0, 1'b1);
      // Every pin and software enable pairing; only both set redirects.
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         ext_pin <= i[0];
         wreg(ilod_pkg::REG_CTRL, {31'h0, i[1]});
         rchk(ilod_pkg::REG_CTRL, {30'h0, i[1] & i[0], i[1]}, 1'b0);
         wreg(ilod_pkg::REG_PTR, 32'h0000_0a00);
         issue({6'h09, 2'b00, 8'h2c}, 8'h17, 8'h20);
         issue({4'h8, 3'h7, 1'b0, 8'h0a}, 8'h00, 8'h55);
         issue({7'h34, 1'b0, 8'h80}, 8'h00, 8'h00);
      end
      // Boundary offsets, wrap of the pointer sum and banked access.
      wreg(ilod_pkg::REG_PTR, 32'h0);
      issue({6'h09, 2'b10, 8'h5f}, 8'h01, 8'h02);
      issue({6'h09, 2'b00, 8'h60}, 8'h7f, 8'h01);
      wreg(ilod_pkg::REG_PTR, 32'h0000_0fc0);
      issue({7'h34, 1'b0, 8'h5f}, 8'h00, 8'h00);
      wreg(ilod_pkg::REG_BANK, 32'h3);
      issue({6'h09, 2'b01, 8'h10}, 8'hff, 8'h01);
      for (i = 0; i < 8; i++)
         issue({4'h8, i[2:0], 1'b0, 8'h0a}, 8'h00, 8'h55);
      // A frozen core must keep its last decode despite a new word.
      // The frozen word is offered as valid so a leak would show up.
      @(posedge clk);
      clk_en     <= 1'b0;
      insn_valid <= 1'b1;
      insn_word  <= 16'h6840;
      repeat (3) @(posedge clk);
      #1;
      check(eff_addr, last_res[11:0]);
      check(res_valid, 1'b0);
      @(posedge clk);
      clk_en     <= 1'b1;
      insn_valid <= 1'b0;
      // Random traffic with occasional pointer, bank and pin changes.
      for (i = 0; i < 300; i++) begin
         f = ($urandom % 3 == 0) ? 8'h5e + 8'($urandom % 3) : 8'($urandom);
         case ($urandom % 4)
            0: w = {6'h09, 2'($urandom), f};
            1: w = {4'h8, 4'($urandom), f};
            2: w = {7'h34, 1'($urandom), f};
            default: w = 16'($urandom);
         endcase
         if ($urandom % 16 == 0) begin
            @(posedge clk);
            ext_pin <= 1'($urandom);
            wreg(ilod_pkg::REG_PTR, $urandom);
            wreg(ilod_pkg::REG_BANK, $urandom);
         end
         issue(w, 8'($urandom), 8'($urandom));
      end
      rchk(ilod_pkg::REG_INSN, {16'h0, last_word}, 1'b0);
      rchk(ilod_pkg::REG_RESULT, {19'h0, last_res}, 1'b0);
      rchk(ilod_pkg::REG_STATUS, {27'h0, last_flags}, 1'b0);
      end_of_test();
   end

   // Watchdog: the run needs well under 10000 cycles.
   initial begin
      #40000;
      num_errors++;
      end_of_test();
   end
endmodule
